// ===== hdl/mep_pkg.sv
// package of constants shared by the event and pn update block
package mep_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_IG_FLAGS    = 8'h00;  // ingress crypto_fault_flags, w1c
  localparam logic [7:0] OFS_EG_FLAGS    = 8'h04;  // egress crypto_fault_flags, w1c
  localparam logic [7:0] OFS_IG_MASK     = 8'h08;  // ingress crypto flag enables
  localparam logic [7:0] OFS_EG_MASK     = 8'h0C;  // egress crypto flag enables
  localparam logic [7:0] OFS_DROP_FLAGS  = 8'h10;  // drop event flags, w1c
  localparam logic [7:0] OFS_DROP_MASK   = 8'h14;  // drop event enables
  localparam logic [7:0] OFS_PN_LIMIT    = 8'h18;  // pn_warning_limit
  localparam logic [7:0] OFS_PN_LOW      = 8'h1C;  // pn_target_low
  localparam logic [7:0] OFS_PN_HIGH     = 8'h20;  // pn_target_high
  localparam logic [7:0] OFS_PN_SEL      = 8'h24;  // pn_target_flow_sel
  localparam logic [7:0] OFS_UPD_CTRL    = 8'h28;  // update request and xpn select
  localparam logic [7:0] OFS_STAT_CTRL   = 8'h2C;  // counter mode and sa select
  localparam logic [7:0] OFS_RX_OCT_W0   = 8'h30;  // sa_rx_octet_counter bits 31:0
  localparam logic [7:0] OFS_RX_OCT_W1   = 8'h34;  // bits 63:32
  localparam logic [7:0] OFS_RX_OCT_W2   = 8'h38;  // bits 79:64, clear point
  localparam logic [7:0] OFS_TX_PKT_W0   = 8'h3C;  // sa_tx_pkt_counter bits 31:0
  localparam logic [7:0] OFS_TX_PKT_W1   = 8'h40;  // bits 39:32, clear point

  // crypto_fault_flags fields
  localparam int FLT_W        = 15;
  localparam int FLT_IN_ERR   = 0;
  localparam int FLT_OUT_ERR  = 1;
  localparam int FLT_PROC_ERR = 2;
  localparam int FLT_CTX_ERR  = 3;
  localparam int FLT_PN_WARN  = 4;
  localparam int FLT_FATAL    = 14;
  localparam logic [FLT_W-1:0] FLT_IMPL = 15'h401F;  // implemented flag bits

  // drop flag fields
  localparam int DROP_W      = 7;
  localparam int D_IG_CLASS  = 0;
  localparam int D_IG_CONS   = 1;
  localparam int D_IG_POST   = 2;
  localparam int D_IG_MTU    = 3;
  localparam int D_EG_CLASS  = 4;
  localparam int D_EG_POST   = 5;
  localparam int D_EG_MTU    = 6;

  // control fields
  localparam int UPD_REQ_BIT = 0;
  localparam int UPD_XPN_BIT = 1;
  localparam int ST_COR_BIT  = 0;
  localparam int ST_SAT_BIT  = 1;
  localparam int ST_SEL_LSB  = 4;

  // reset values
  localparam logic [31:0] PN_LIMIT_RST  = 32'hF000_0000;
  localparam logic [FLT_W-1:0] MASK_RST = 15'h0000;
  localparam logic [DROP_W-1:0] DMASK_RST = 7'h00;

  // counter widths and limits
  localparam int RX_OCT_W = 80;
  localparam int TX_PKT_W = 40;
  localparam logic [79:0] RX_MAX = 80'hFFFF_FFFF_FFFF_FFFF_FFFF;
  localparam logic [79:0] TX_MAX = 80'h0000_0000_00FF_FFFF_FFFF;

  // pn update sequencer states
  typedef enum logic [0:0] {UPD_IDLE, UPD_CMP} mep_upd_state_t;
endpackage

// ===== hdl/mep_ctx_mem.sv
// per-flow sequence number store with registered read data
`timescale 1ns/10ps
module mep_ctx_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 64
) (
  input  wire logic                     hclk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         wdata,
  output logic      [WIDTH-1:0]         rdata
);
  logic [WIDTH-1:0] mem [DEPTH];  // one word per flow context

  // read first, a write returns the old word; read data lands one cycle after the address
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ===== hdl/mep_event_pn.sv
// event flags, drop interrupts, sa counters and ingress pn update
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module mep_event_pn import mep_pkg::*; #(
  parameter int NUM_SA  = 4,
  parameter int NUM_CTX = 16
) (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  input  wire logic [1:0]                     cc_chk,
  input  wire logic [1:0][15:0]               cc_pkt_len,
  input  wire logic [1:0][5:0]                cc_sl_len,
  input  wire logic [1:0]                     cc_flow_egress,
  input  wire logic [1:0]                     cc_rec_egress,
  input  wire logic [1:0]                     cc_cipher_ok,
  input  wire logic [1:0]                     cc_auth_ok,
  input  wire logic [1:0]                     cc_out_err,
  input  wire logic [1:0]                     cc_fatal,
  input  wire logic [1:0]                     cc_proc_hw,
  input  wire logic                           eg_pn_valid,
  input  wire logic [31:0]                    eg_pn,
  input  wire logic                           ig_drop_class,
  input  wire logic                           ig_drop_consist,
  input  wire logic                           ig_drop_post,
  input  wire logic                           ig_drop_mtu,
  input  wire logic                           eg_drop_class,
  input  wire logic                           eg_drop_post,
  input  wire logic                           eg_drop_mtu,
  input  wire logic                           sa_rx_evt,
  input  wire logic [$clog2(NUM_SA)-1:0]      sa_rx_idx,
  input  wire logic [15:0]                    sa_rx_octets,
  input  wire logic                           sa_tx_evt,
  input  wire logic [$clog2(NUM_SA)-1:0]      sa_tx_idx,
  input  wire logic                           rec_wr_en,
  input  wire logic [$clog2(NUM_CTX)-1:0]     rec_idx,
  input  wire logic [63:0]                    rec_wr_pn,
  output logic                                rec_ready,
  output logic      [63:0]                    ctx_rd_pn,
  output logic                                ig_irq_crypto,
  output logic                                ig_irq_class,
  output logic                                ig_irq_consist,
  output logic                                ig_irq_post,
  output logic                                ig_irq_mtu,
  output logic                                eg_irq_crypto,
  output logic                                eg_irq_class,
  output logic                                eg_irq_post,
  output logic                                eg_irq_mtu
);
  localparam int SAW = $clog2(NUM_SA);
  localparam int CXW = $clog2(NUM_CTX);
  // crypto checks of one direction folded into flag events
  function automatic logic [FLT_W-1:0] flt_events(input logic chk, input logic [15:0] len,
      input logic [5:0] sl, input logic flow_eg, input logic rec_eg, input logic cip_ok,
      input logic auth_ok, input logic out_err, input logic fatal, input logic proc_hw);
    logic [FLT_W-1:0] v;
    v = '0;
    v[FLT_IN_ERR]   = chk && (sl != 6'h00) && (len < {10'h000, sl});
    v[FLT_OUT_ERR]  = out_err;
    v[FLT_FATAL]    = fatal;
    v[FLT_PROC_ERR] = (chk && (flow_eg != rec_eg)) || proc_hw;
    v[FLT_CTX_ERR]  = chk && !(cip_ok && auth_ok);
    return v;
  endfunction
  // counter step with wrap inside the limit or saturation at it
  function automatic logic [79:0] cnt_add(input logic [79:0] cur, input logic [79:0] inc,
      input logic [79:0] maxv, input logic sat);
    logic [80:0] s;
    s = {1'b0, cur} + {1'b0, inc};
    if (sat && (s > {1'b0, maxv})) begin
      return maxv;
    end
    return s[79:0] & maxv;
  endfunction
  // register state
  logic [FLT_W-1:0]  ig_flags_q, eg_flags_q;   // latched crypto flags
  logic [FLT_W-1:0]  ig_mask_q, eg_mask_q;     // crypto flag enables
  logic [DROP_W-1:0] drop_flags_q, drop_mask_q;  // drop flags and enables
  logic [31:0]       pn_warning_limit_q;       // egress pn warning level
  logic [31:0]       pn_target_low_q, pn_target_high_q;
  logic [CXW-1:0]    pn_target_flow_sel_q;
  logic              upd_req_q, upd_xpn_q;     // update request and 64-bit select
  logic [7:0]        stat_ctrl_q;              // clear-on-read, saturate, sa select
  logic [RX_OCT_W-1:0] rx_oct_q [NUM_SA];      // sa_rx_octet_counter
  logic [TX_PKT_W-1:0] tx_pkt_q [NUM_SA];      // sa_tx_pkt_counter
  mep_upd_state_t    upd_state_q;
  // ahb-lite data phase state
  logic              wr_q;                     // write pending in data phase
  logic [7:0]        waddr_q;                  // its offset
  logic [31:0]       hrdata_q;                 // read data, from a flop
  // address phase decode
  wire         addr_ph = hsel && hready && htrans[1];
  wire         rd_ph   = addr_ph && !hwrite;
  wire  [7:0]  raddr   = haddr[7:0];
  wire         wr_hit_ig   = wr_q && (waddr_q == OFS_IG_FLAGS);
  wire         wr_hit_eg   = wr_q && (waddr_q == OFS_EG_FLAGS);
  wire         wr_hit_drop = wr_q && (waddr_q == OFS_DROP_FLAGS);
  wire         wr_hit_upd  = wr_q && (waddr_q == OFS_UPD_CTRL);
  wire [SAW-1:0] sa_sel    = stat_ctrl_q[ST_SEL_LSB +: SAW];
  wire         cor_en      = stat_ctrl_q[ST_COR_BIT];
  wire         sat_en      = stat_ctrl_q[ST_SAT_BIT];
  wire         rx_clr      = rd_ph && cor_en && (raddr == OFS_RX_OCT_W2);
  wire         tx_clr      = rd_ph && cor_en && (raddr == OFS_TX_PKT_W1);
  // hardware set terms; egress pn passing the limit is only a warning
  logic [FLT_W-1:0] ig_set, eg_set;
  logic [DROP_W-1:0] drop_set;
  assign ig_set = flt_events(cc_chk[0], cc_pkt_len[0], cc_sl_len[0], cc_flow_egress[0],
                             cc_rec_egress[0], cc_cipher_ok[0], cc_auth_ok[0], cc_out_err[0],
                             cc_fatal[0], cc_proc_hw[0]);
  assign eg_set = flt_events(cc_chk[1], cc_pkt_len[1], cc_sl_len[1], cc_flow_egress[1],
                             cc_rec_egress[1], cc_cipher_ok[1], cc_auth_ok[1], cc_out_err[1],
                             cc_fatal[1], cc_proc_hw[1])
                | (FLT_W'(eg_pn_valid && (eg_pn > pn_warning_limit_q)) << FLT_PN_WARN);
  assign drop_set = {eg_drop_mtu, eg_drop_post, eg_drop_class,
                     ig_drop_mtu, ig_drop_post, ig_drop_consist, ig_drop_class};
  // w1c: a set arriving with the clear wins
  wire [FLT_W-1:0]  ig_flags_d   = (ig_flags_q & ~(wr_hit_ig ? hwdata[FLT_W-1:0] : '0)) | ig_set;
  wire [FLT_W-1:0]  eg_flags_d   = (eg_flags_q & ~(wr_hit_eg ? hwdata[FLT_W-1:0] : '0)) | eg_set;
  wire [DROP_W-1:0] drop_flags_d = (drop_flags_q & ~(wr_hit_drop ? hwdata[DROP_W-1:0] : '0)) | drop_set;
  // interrupt lines follow flag and enable, no extra latency
  wire [FLT_W-1:0]  ig_act = ig_flags_q & ig_mask_q;
  wire [FLT_W-1:0]  eg_act = eg_flags_q & eg_mask_q;
  wire [DROP_W-1:0] d_act  = drop_flags_q & drop_mask_q;
  assign ig_irq_crypto  = |ig_act;
  assign eg_irq_crypto  = |eg_act;
  assign ig_irq_class   = d_act[D_IG_CLASS];
  assign ig_irq_consist = d_act[D_IG_CONS];
  assign ig_irq_post    = d_act[D_IG_POST];
  assign ig_irq_mtu     = d_act[D_IG_MTU];
  assign eg_irq_class   = d_act[D_EG_CLASS];
  assign eg_irq_post    = d_act[D_EG_POST];
  assign eg_irq_mtu     = d_act[D_EG_MTU];
  // pn update datapath; host owns the memory port while a request is open
  logic [63:0] mem_rd;
  wire  [63:0] tgt_pn  = upd_xpn_q ? {pn_target_high_q, pn_target_low_q} : {32'h0000_0000, pn_target_low_q};
  wire         pn_less = upd_xpn_q ? (mem_rd < tgt_pn) : (mem_rd[31:0] < pn_target_low_q);
  wire         upd_wr  = (upd_state_q == UPD_CMP) && pn_less;
  wire         upd_done = (upd_state_q == UPD_CMP);
  wire         mem_we  = upd_req_q ? upd_wr : rec_wr_en;
  wire [CXW-1:0] mem_addr = upd_req_q ? pn_target_flow_sel_q : rec_idx;
  wire [63:0]  mem_wd  = upd_req_q ? tgt_pn : rec_wr_pn;
  assign rec_ready = !upd_req_q;
  assign ctx_rd_pn = mem_rd;
  mep_ctx_mem #(.DEPTH(NUM_CTX), .WIDTH(64)) i_mep_ctx_mem (
    .hclk  (hclk),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wd),
    .rdata (mem_rd)
  );
  // read mux, sampled in the address phase
  logic [31:0] rd_mux;
  always_comb begin
    case (raddr)
      OFS_IG_FLAGS:   rd_mux = {17'h0, ig_flags_q};
      OFS_EG_FLAGS:   rd_mux = {17'h0, eg_flags_q};
      OFS_IG_MASK:    rd_mux = {17'h0, ig_mask_q};
      OFS_EG_MASK:    rd_mux = {17'h0, eg_mask_q};
      OFS_DROP_FLAGS: rd_mux = {25'h0, drop_flags_q};
      OFS_DROP_MASK:  rd_mux = {25'h0, drop_mask_q};
      OFS_PN_LIMIT:   rd_mux = pn_warning_limit_q;
      OFS_PN_LOW:     rd_mux = pn_target_low_q;
      OFS_PN_HIGH:    rd_mux = pn_target_high_q;
      OFS_PN_SEL:     rd_mux = 32'(pn_target_flow_sel_q);
      OFS_UPD_CTRL:   rd_mux = {30'h0, upd_xpn_q, upd_req_q};
      OFS_STAT_CTRL:  rd_mux = {24'h0, stat_ctrl_q};
      OFS_RX_OCT_W0:  rd_mux = rx_oct_q[sa_sel][31:0];
      OFS_RX_OCT_W1:  rd_mux = rx_oct_q[sa_sel][63:32];
      OFS_RX_OCT_W2:  rd_mux = {16'h0, rx_oct_q[sa_sel][79:64]};
      OFS_TX_PKT_W0:  rd_mux = tx_pkt_q[sa_sel][31:0];
      OFS_TX_PKT_W1:  rd_mux = {24'h0, tx_pkt_q[sa_sel][39:32]};
      default:        rd_mux = 32'h0000_0000;  // unmapped reads as zero
    endcase
  end

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  // bus phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q     <= 1'b0;
      waddr_q  <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q    <= addr_ph && hwrite;
      waddr_q <= raddr;
      if (rd_ph) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // flags and software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ig_flags_q           <= '0;
      eg_flags_q           <= '0;
      drop_flags_q         <= '0;
      ig_mask_q            <= MASK_RST;
      eg_mask_q            <= MASK_RST;
      drop_mask_q          <= DMASK_RST;
      pn_warning_limit_q   <= PN_LIMIT_RST;
      pn_target_low_q      <= 32'h0000_0000;
      pn_target_high_q     <= 32'h0000_0000;
      pn_target_flow_sel_q <= '0;
      stat_ctrl_q          <= 8'h00;
    end else begin
      ig_flags_q   <= ig_flags_d;
      eg_flags_q   <= eg_flags_d;
      drop_flags_q <= drop_flags_d;
      if (wr_q) begin
        case (waddr_q)
          OFS_IG_MASK:   ig_mask_q            <= hwdata[FLT_W-1:0] & FLT_IMPL;
          OFS_EG_MASK:   eg_mask_q            <= hwdata[FLT_W-1:0] & FLT_IMPL;
          OFS_DROP_MASK: drop_mask_q          <= hwdata[DROP_W-1:0];
          OFS_PN_LIMIT:  pn_warning_limit_q   <= hwdata;
          OFS_PN_LOW:    pn_target_low_q      <= hwdata;
          OFS_PN_HIGH:   pn_target_high_q     <= hwdata;
          OFS_PN_SEL:    pn_target_flow_sel_q <= hwdata[CXW-1:0];
          OFS_STAT_CTRL: stat_ctrl_q          <= hwdata[7:0];
          default: ;  // flags, counters and unmapped: no store
        endcase
      end
    end
  end

  // update request: software sets, sequencer clears when the record is done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upd_req_q   <= 1'b0;
      upd_xpn_q   <= 1'b0;
      upd_state_q <= UPD_IDLE;
    end else begin
      if (wr_hit_upd) begin
        upd_xpn_q <= hwdata[UPD_XPN_BIT];
      end
      if (wr_hit_upd && hwdata[UPD_REQ_BIT]) begin
        upd_req_q <= 1'b1;  // set wins over completion
      end else if (upd_done) begin
        upd_req_q <= 1'b0;
      end
      case (upd_state_q)
        UPD_IDLE: upd_state_q <= upd_req_q ? UPD_CMP : UPD_IDLE;  // read issued here
        UPD_CMP:  upd_state_q <= UPD_IDLE;  // compare and conditional write
        default:  upd_state_q <= UPD_IDLE;
      endcase
    end
  end

  // per-sa counters; one counter serves both cipher modes of its sa
  for (genvar g = 0; g < NUM_SA; g++) begin : g_cnt
    logic [79:0] rx_sum, tx_sum;
    assign rx_sum = cnt_add(rx_oct_q[g], {64'h0, sa_rx_octets}, RX_MAX, sat_en);
    assign tx_sum = cnt_add({40'h0, tx_pkt_q[g]}, 80'h1, TX_MAX, sat_en);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rx_oct_q[g] <= '0;
        tx_pkt_q[g] <= '0;
      end else begin
        if (rx_clr && (sa_sel == SAW'(g))) begin
          rx_oct_q[g] <= (sa_rx_evt && (sa_rx_idx == SAW'(g))) ? {64'h0, sa_rx_octets} : '0;
        end else if (sa_rx_evt && (sa_rx_idx == SAW'(g))) begin
          rx_oct_q[g] <= rx_sum;
        end
        if (tx_clr && (sa_sel == SAW'(g))) begin
          tx_pkt_q[g] <= (sa_tx_evt && (sa_tx_idx == SAW'(g))) ? 40'h1 : '0;
        end else if (sa_tx_evt && (sa_tx_idx == SAW'(g))) begin
          tx_pkt_q[g] <= tx_sum[TX_PKT_W-1:0];
        end
      end
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_in_err_set: assert property (cc_chk[0] && |cc_sl_len[0] && cc_pkt_len[0] < 16'(cc_sl_len[0])
    |=> ig_flags_q[FLT_IN_ERR]) else $error("short packet did not set input error");
  chk_pn_warn: assert property (eg_pn_valid && eg_pn > pn_warning_limit_q
    |=> eg_flags_q[FLT_PN_WARN]) else $error("pn over limit did not warn");
  chk_w1c_clear: assert property (wr_hit_ig && hwdata[FLT_CTX_ERR] && !ig_set[FLT_CTX_ERR]
    |=> !ig_flags_q[FLT_CTX_ERR]) else $error("w1c did not clear flag");
  chk_class_irq: assert property (ig_drop_class && drop_mask_q[D_IG_CLASS] && !wr_q
    |=> ig_irq_class) else $error("classification drop not raised");
  chk_consist_irq: assert property (ig_drop_consist && drop_mask_q[D_IG_CONS] && !wr_q
    |=> ig_irq_consist) else $error("consistency drop not raised");
  chk_post_irq: assert property (eg_drop_post && drop_mask_q[D_EG_POST] && !wr_q
    |=> eg_irq_post) else $error("post drop not raised");
  chk_mtu_irq: assert property (eg_drop_mtu && drop_mask_q[D_EG_MTU] && !wr_q
    |=> eg_irq_mtu) else $error("mtu drop not raised");
  chk_irq_drop: assert property ($fell(drop_mask_q[D_IG_MTU]) |-> !ig_irq_mtu)
    else $error("masked interrupt still high");
  chk_upd_raise: assert property (upd_state_q == UPD_CMP && !upd_xpn_q && mem_rd[31:0] < pn_target_low_q
    |-> mem_we && mem_wd == {32'h0000_0000, pn_target_low_q}) else $error("smaller pn not raised");
  chk_upd_keep: assert property (upd_state_q == UPD_CMP && !upd_xpn_q && mem_rd[31:0] >= pn_target_low_q
    |-> !mem_we) else $error("record written although pn not smaller");
  chk_upd_done: assert property ($rose(upd_req_q) |-> ##[1:3] !upd_req_q)
    else $error("update request not cleared");
  cov_upd_write: cover property (upd_wr);
  cov_upd_skip: cover property (upd_done && !pn_less);
  cov_pn_warn: cover property (eg_irq_crypto && eg_flags_q[FLT_PN_WARN]);
  cov_sat: cover property (sat_en && sa_tx_evt && tx_pkt_q[sa_tx_idx] == TX_MAX[TX_PKT_W-1:0]);
endmodule

// ===== bench/test_mep_event_pn.sv
// self-checking bench for the event flags and pn update block
`timescale 1ns/10ps
module test_mep_event_pn import mep_pkg::*; ();
  logic              hclk = 1'b0;             // system clock
  logic              hresetn = 1'b0;          // active low reset
  logic              hsel = 1'b0;             // bus select
  logic [31:0]       haddr = 32'h0;           // bus address
  logic [1:0]        htrans = 2'h0;           // bus transfer kind
  logic              hwrite = 1'b0;           // write strobe
  logic [31:0]       hwdata = 32'h0;          // write data
  logic [18:0]       p = 19'h0;               // all event pulses in one vector
  logic [1:0][15:0]  cc_pkt_len = '0;         // real packet lengths
  logic [1:0][5:0]   cc_sl_len = '0;          // short-length fields
  logic [1:0]        cc_flow_egress = 2'h2;   // flow directions
  logic [1:0]        cc_rec_egress = 2'h2;    // record directions
  logic [1:0]        cc_cipher_ok = 2'h3;     // cipher settings valid
  logic [1:0]        cc_auth_ok = 2'h3;       // auth settings valid
  logic [31:0]       eg_pn = 32'h0;           // egress packet number
  logic [1:0]        sa_rx_idx = 2'h0;        // rx counter select
  logic [1:0]        sa_tx_idx = 2'h0;        // tx counter select
  logic [15:0]       sa_rx_octets = 16'h0;    // octets to add
  logic [3:0]        rec_idx = 4'h0;          // context index
  logic [63:0]       rec_wr_pn = 64'h0;       // context load value
  wire logic [31:0]  hrdata;                  // read data
  wire logic         hreadyout;               // bus ready, also fed back as hready
  wire logic         hresp;                   // response, checked okay on reads
  wire logic         rec_ready;               // update idle
  wire logic [63:0]  ctx_rd_pn;               // context read data
  wire logic [6:0]   dirq;                    // drop lines in drop flag order
  wire logic [1:0]   cirq;                    // crypto lines, 0 ingress 1 egress
  int                n_errors = 0;            // mismatches
  int                checks_done = 0;         // comparisons
  int                cycles = 0;              // hang guard

  mep_event_pn i_mep_event_pn (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cc_chk(p[1:0]), .cc_pkt_len(cc_pkt_len), .cc_sl_len(cc_sl_len), .cc_flow_egress(cc_flow_egress),
    .cc_rec_egress(cc_rec_egress), .cc_cipher_ok(cc_cipher_ok), .cc_auth_ok(cc_auth_ok), .cc_out_err(p[3:2]),
    .cc_fatal(p[5:4]), .cc_proc_hw(p[7:6]), .eg_pn_valid(p[8]), .eg_pn(eg_pn), .ig_drop_class(p[11]),
    .ig_drop_consist(p[12]), .ig_drop_post(p[13]), .ig_drop_mtu(p[14]), .eg_drop_class(p[15]), .eg_drop_post(p[16]),
    .eg_drop_mtu(p[17]), .sa_rx_evt(p[10]), .sa_rx_idx(sa_rx_idx), .sa_rx_octets(sa_rx_octets), .sa_tx_evt(p[9]),
    .sa_tx_idx(sa_tx_idx), .rec_wr_en(p[18]), .rec_idx(rec_idx), .rec_wr_pn(rec_wr_pn), .rec_ready(rec_ready),
    .ctx_rd_pn(ctx_rd_pn), .ig_irq_crypto(cirq[0]), .ig_irq_class(dirq[0]), .ig_irq_consist(dirq[1]),
    .ig_irq_post(dirq[2]), .ig_irq_mtu(dirq[3]), .eg_irq_crypto(cirq[1]), .eg_irq_class(dirq[4]),
    .eg_irq_post(dirq[5]), .eg_irq_mtu(dirq[6]));

  // free running clock
  initial begin
    forever #5 hclk = ~hclk;
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end

  // one comparison, counted
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // single word transfer, waits on ready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(nm, {32'h0, e}, {32'h0, r});
    chk("okay response", 64'h0, {63'h0, hresp});
  endtask

  // flag read, write-one clear, read back empty
  task automatic flt(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, e, nm);
    wr(a, e);
    rd(a, 32'h0, nm);
  endtask

  // one-cycle event pulse; the flag lands on the returning edge
  task automatic pulse(input int i);
    @(posedge hclk);
    p <= 19'h1 << i;
    @(posedge hclk);
    p <= '0;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_PN_LIMIT, PN_LIMIT_RST, "limit reset");
    rd(8'hFC, 32'h0, "unmapped");
    wr(OFS_DROP_MASK, 32'h7F);
    // each drop line alone, unmasked
    for (int i = 0; i < 7; i++) begin
      pulse(11 + i);
      #1 chk("drop irq", 64'h1 << i, {57'h0, dirq});
      flt(OFS_DROP_FLAGS, 32'h1 << i, "drop flag");
      #1 chk("drop irq clear", 64'h0, {57'h0, dirq});
    end
    // masking alone must drop the line but keep the flag
    pulse(14);
    wr(OFS_DROP_MASK, 32'h0);
    #1 chk("masked irq", 64'h0, {57'h0, dirq});
    flt(OFS_DROP_FLAGS, 32'h8, "masked flag");
    wr(OFS_IG_MASK, 32'h401F);
    wr(OFS_EG_MASK, 32'h401F);
    cc_sl_len[0] <= 6'd20;
    cc_pkt_len[0] <= 16'd19;
    pulse(0);
    #1 chk("crypto irq", 64'h1, {63'h0, cirq[0]});
    flt(OFS_IG_FLAGS, 32'h1, "input error");
    cc_pkt_len[0] <= 16'd20;
    pulse(0);
    flt(OFS_IG_FLAGS, 32'h0, "length equal");
    pulse(2);
    flt(OFS_IG_FLAGS, 32'h2, "output error");
    pulse(4);
    flt(OFS_IG_FLAGS, 32'h4000, "fatal error");
    pulse(6);
    flt(OFS_IG_FLAGS, 32'h4, "hw processing");
    pulse(3);
    flt(OFS_EG_FLAGS, 32'h2, "egress output");
    cc_rec_egress[0] <= 1'b1;
    pulse(0);
    flt(OFS_IG_FLAGS, 32'h4, "direction");
    cc_rec_egress[0] <= 1'b0;
    cc_cipher_ok[0] <= 1'b0;
    pulse(0);
    flt(OFS_IG_FLAGS, 32'h8, "context error");
    cc_cipher_ok[0] <= 1'b1;
    eg_pn <= PN_LIMIT_RST;
    pulse(8);
    flt(OFS_EG_FLAGS, 32'h0, "pn at limit");
    eg_pn <= PN_LIMIT_RST + 32'h1;
    pulse(8);
    #1 chk("warn irq", 64'h1, {63'h0, cirq[1]});
    // software handling: mask the warning, clear it, then unmask
    wr(OFS_EG_MASK, 32'h400F);
    #1 chk("warn masked", 64'h0, {63'h0, cirq[1]});
    flt(OFS_EG_FLAGS, 32'h10, "pn over limit");
    wr(OFS_EG_MASK, 32'h401F);
    #1 chk("warn unmasked", 64'h0, {63'h0, cirq[1]});
    // per-sa counters on sa 1
    wr(OFS_STAT_CTRL, 32'h10);
    sa_tx_idx <= 2'd1;
    sa_rx_idx <= 2'd1;
    sa_rx_octets <= 16'd100;
    pulse(9);
    pulse(9);
    pulse(10);
    rd(OFS_TX_PKT_W0, 32'h2, "tx packets");
    rd(OFS_RX_OCT_W0, 32'd100, "rx octets");
    wr(OFS_STAT_CTRL, 32'h11);
    rd(OFS_TX_PKT_W1, 32'h0, "tx high");
    rd(OFS_TX_PKT_W0, 32'h0, "tx cleared");
    rd(OFS_RX_OCT_W2, 32'h0, "rx top");
    rd(OFS_RX_OCT_W0, 32'h0, "rx cleared");
    // context 3 holds 500; raise to 1000, then try 400 and 1000 again
    rec_idx <= 4'd3;
    rec_wr_pn <= 64'd500;
    pulse(18);
    wr(OFS_PN_HIGH, 32'h0);
    wr(OFS_PN_SEL, 32'h3);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_PN_LOW, (k == 1) ? 32'd400 : 32'd1000);
      wr(OFS_UPD_CTRL, 32'h1);
      #1 chk("record busy", 64'h0, {63'h0, rec_ready});
      repeat (4) @(posedge hclk);
      rd(OFS_UPD_CTRL, 32'h0, "request cleared");
      chk("context pn", 64'd1000, ctx_rd_pn);
      chk("record idle", 64'h1, {63'h0, rec_ready});
    end
    final_report();
  end
endmodule
